// ==== crs_stream.sv ====
// Completer request output stage with non-posted credit pacing
module crs_stream (
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  input  wire logic                         link_up,
  input  wire logic                         straddle_enable,
  input  wire logic                         src_valid,
  output logic                              src_ready,
  input  wire logic [crs_pkg::DATA_W-1:0]   src_data,
  input  wire logic [crs_pkg::SIDE_W-1:0]   src_sideband,
  input  wire logic                         src_packet_end,
  input  wire logic [crs_pkg::IDX_W-1:0]    src_last_dword,
  input  wire logic                         src_nonposted,
  input  wire logic [1:0]                   nonposted_credit_grant,
  output logic      [crs_pkg::CREDIT_W-1:0] nonposted_credit_level,
  output logic      [crs_pkg::DATA_W-1:0]   req_stream_data,
  output logic      [crs_pkg::SIDE_W-1:0]   req_stream_sideband,
  output logic                              req_stream_packet_end,
  output logic      [crs_pkg::MASK_W-1:0]   req_stream_dword_mask,
  output logic                              req_stream_valid,
  input  wire logic                         req_stream_ready
);
  import crs_pkg::*;

  // Ones from Dword 0 up to and including the last Dword
  function automatic logic [MASK_W-1:0] mask_upto(input logic [IDX_W-1:0] last);
    logic [MASK_W-1:0] m;
    m = '0;
    for (int i = 0; i < MASK_W; i++) begin
      m[i] = (i <= int'(last));
    end
    return m;
  endfunction

  // ****************************************************************
  // Intake decode
  // ****************************************************************
  logic              src_in_pkt;
  logic              out_last;
  logic [MASK_W-1:0] out_mask;
  wire               credit_avail;
  wire               stage_free;
  wire               src_first;
  wire               np_paused;
  wire               src_take;
  wire               consume;
  wire [MASK_W-1:0]  beat_mask;

  assign stage_free = !req_stream_valid || req_stream_ready;
  assign src_first  = !src_in_pkt;
  // Only the head of a non-posted packet waits for credit; posted traffic passes
  assign np_paused  = src_first && src_nonposted && !credit_avail;
  assign src_ready  = stage_free && !np_paused;
  assign src_take   = src_valid && src_ready;
  assign consume    = src_take && src_first && src_nonposted;
  // Same rule for Dword-aligned and address-aligned payload layouts
  assign beat_mask  = src_packet_end ? mask_upto(src_last_dword) : MASK_ALL;

  // ****************************************************************
  // Output stage
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      src_in_pkt <= 1'b0;
    end else if (src_take) begin
      src_in_pkt <= !src_packet_end;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      req_stream_valid <= 1'b0;
    end else if (stage_free) begin
      req_stream_valid <= src_take;
    end
  end

  // Data registers load only when the stage frees; a stall holds them
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      req_stream_data     <= '0;
      req_stream_sideband <= '0;
      out_last            <= 1'b0;
      out_mask            <= MASK_ALL;
    end else if (src_take) begin
      req_stream_data     <= src_data;
      req_stream_sideband <= src_sideband;
      out_last            <= src_packet_end;
      out_mask            <= beat_mask;
    end
  end

  // Straddle is a static option; packets are then framed by sideband flags only
  assign req_stream_packet_end = out_last && !straddle_enable;
  assign req_stream_dword_mask = straddle_enable ? MASK_ALL : out_mask;

  crs_credit u_credit (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .link_up      (link_up),
    .grant        (nonposted_credit_grant),
    .consume      (consume),
    .credit_avail (credit_avail),
    .level        (nonposted_credit_level)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence stalled_beat;
    req_stream_valid && !req_stream_ready;
  endsequence

  sequence held_beat;
    req_stream_valid && $stable(req_stream_data) && $stable(req_stream_sideband);
  endsequence

  a_stall_hold: assert property (stalled_beat |=> held_beat)
    else $error("stalled beat changed or dropped");
  a_valid_drop: assert property ($fell(req_stream_valid) |-> $past(req_stream_ready))
    else $error("valid dropped without a transfer");
  a_no_load_stall: assert property (stalled_beat |-> !src_ready)
    else $error("source accepted into a stalled stage");
  a_straddle_end: assert property (straddle_enable |-> !req_stream_packet_end)
    else $error("packet end raised with straddle on");
  a_straddle_mask: assert property (straddle_enable |-> req_stream_dword_mask == MASK_ALL)
    else $error("mask not all ones with straddle on");
  a_mid_mask: assert property (
    req_stream_valid && !straddle_enable && !req_stream_packet_end
    |-> req_stream_dword_mask == MASK_ALL)
    else $error("mask not full before final beat");
  a_mask_contig: assert property (
    req_stream_valid |-> req_stream_dword_mask[0]
    && ((req_stream_dword_mask & (req_stream_dword_mask + 16'h0001)) == 16'h0000))
    else $error("mask not contiguous from Dword 0");
  a_end_follows: assert property (
    src_take && src_packet_end && !straddle_enable |=> req_stream_packet_end)
    else $error("final beat lacks packet end");
  a_np_pause: assert property (src_valid && np_paused |-> !src_ready)
    else $error("non-posted head taken without credit");
  a_posted_flows: assert property (
    src_valid && stage_free && src_first && !src_nonposted |-> src_take)
    else $error("posted packet blocked");

endmodule : crs_stream

// ==== crs_pkg.sv ====
// Constants for the 512-bit completer request output stream
// Function
// - Request data leaves on a 512-bit bus.
// - 229-bit sideband, meaningful only while valid.
// - No straddle: packet end on final beat.
// - Straddle: packet end held at zero.
// - No straddle: contiguous Dword mask, full mid-packet.
// - Same mask for both payload alignment modes.
// - Straddle: every mask bit held at one.
// - Valid marks data, held through a packet.
// - Beat moves only when valid and ready.
// - Stalled beat keeps data and valid steady.
// - Credit grant adds zero, one or two.
// - Non-posted delivery spends credit, pauses at zero.
// - Credit level on six bits, saturates at 32.
// - Credit cleared on reset and link loss.
package crs_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int DATA_W   = 512;
  localparam int SIDE_W   = 229;
  localparam int MASK_W   = 16;
  localparam int IDX_W    = 4;
  localparam int CREDIT_W = 6;

  // ****************************************************************
  // Credit counter
  // ****************************************************************
  localparam logic [CREDIT_W-1:0] CREDIT_MAX   = 6'h20;
  localparam logic [CREDIT_W-1:0] CREDIT_RESET = 6'h00;
  localparam logic [1:0]          GRANT_NONE   = 2'h0;
  localparam logic [1:0]          GRANT_ONE    = 2'h1;

  // ****************************************************************
  // Output reset values
  // ****************************************************************
  localparam logic [MASK_W-1:0] MASK_ALL = 16'hFFFF;

endpackage : crs_pkg

// ==== crs_credit.sv ====
// Non-posted request credit counter
module crs_credit (
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  input  wire logic                         link_up,
  input  wire logic [1:0]                   grant,
  input  wire logic                         consume,
  output logic                              credit_avail,
  output logic      [crs_pkg::CREDIT_W-1:0] level
);
  import crs_pkg::*;

  logic [CREDIT_W-1:0] count;
  logic [CREDIT_W:0]   sum;
  logic [CREDIT_W:0]   next_wide;
  logic [CREDIT_W-1:0] next_count;
  logic [1:0]          add;

  // ****************************************************************
  // Next count
  // ****************************************************************
  assign add = (grant == GRANT_NONE) ? 2'h0 : (grant == GRANT_ONE) ? 2'h1 : 2'h2;
  assign sum = {1'b0, count} + {5'h00, add};
  assign next_wide = sum - {6'h00, consume};
  // Saturate so a user holding 11 forever cannot wrap the counter
  assign next_count = (next_wide > {1'b0, CREDIT_MAX}) ? CREDIT_MAX
                    : next_wide[CREDIT_W-1:0];
  assign credit_avail = (count != CREDIT_RESET);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count <= CREDIT_RESET;
      level <= CREDIT_RESET;
    end else begin
      count <= link_up ? next_count : CREDIT_RESET;
      // One cycle of lag on the visible level
      level <= link_up ? count : CREDIT_RESET;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_credit_add_one: assert property (
    link_up && $past(link_up) && grant == GRANT_ONE && !consume && count < 6'h1F
    |=> count == $past(count) + 6'h01)
    else $error("credit did not add one");
  a_credit_add_two: assert property (
    link_up && grant[1] && !consume && count < 6'h1E
    |=> !link_up || count == $past(count) + 6'h02)
    else $error("credit did not add two");
  a_credit_max: assert property (count <= CREDIT_MAX && level <= CREDIT_MAX)
    else $error("credit above saturation limit");
  a_credit_floor: assert property (consume |-> count != CREDIT_RESET)
    else $error("credit spent at zero");
  a_credit_spend: assert property (
    link_up && consume && grant == GRANT_NONE |=> count == $past(count) - 6'h01)
    else $error("credit not spent on delivery");
  a_credit_clear: assert property (!link_up |=> count == CREDIT_RESET ##1 level == CREDIT_RESET)
    else $error("credit not cleared on link loss");

endmodule : crs_credit

// ==== crs_user_model.sv ====
// Behavioural user logic that takes beats off the completer request stream
module crs_user_model (
  input  wire logic       sys_clk,
  input  wire logic [1:0] pace,
  output logic            req_stream_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed = 32'h7a1a;
  initial req_stream_ready = 1'b1;
  // Pace 0 takes every beat, 1 stalls at random, 2 holds off
  always @(negedge sys_clk) begin
    req_stream_ready <= (pace == 2'h0) || (pace == 2'h1 && $random(seed) % 2 == 0);
  end
endmodule // crs_user_model

// ==== testbench.sv ====
// Self-checking bench for the completer request output stage
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import crs_pkg::*;
  logic sys_clk, rst, link_up, straddle_enable, src_valid, src_ready, src_packet_end;
  logic src_nonposted, req_stream_packet_end, req_stream_valid, req_stream_ready;
  logic [DATA_W-1:0] src_data, req_stream_data, d, held;
  logic [SIDE_W-1:0] src_sideband, req_stream_sideband;
  logic [IDX_W-1:0] src_last_dword, l;
  logic [1:0] nonposted_credit_grant, pace;
  logic [CREDIT_W-1:0] nonposted_credit_level, c;
  logic [MASK_W-1:0] req_stream_dword_mask;
  logic [DATA_W-1:0] q_data[$];
  logic q_end[$];
  logic [IDX_W-1:0] q_ld[$];
  logic e, in_pkt = 1'b0, stalled = 1'b0;
  int errors = 0, check_count = 0, seed = 32'h7a1a, i;

  crs_stream u_crs_stream (.sys_clk, .rst, .link_up, .straddle_enable, .src_valid, .src_ready,
    .src_data, .src_sideband, .src_packet_end, .src_last_dword, .src_nonposted,
    .nonposted_credit_grant, .nonposted_credit_level, .req_stream_data, .req_stream_sideband,
    .req_stream_packet_end, .req_stream_dword_mask, .req_stream_valid, .req_stream_ready);
  crs_user_model u_crs_user_model (.sys_clk, .pace, .req_stream_ready);

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic logic [MASK_W-1:0] exp_mask(input logic fin, input logic [IDX_W-1:0] ld);
    if (straddle_enable || !fin) return MASK_ALL;
    return 16'hFFFF >> (4'hF - ld);
  endfunction

  function automatic logic [CREDIT_W-1:0] add(input logic [CREDIT_W-1:0] v, input logic [1:0] g);
    int s;
    s = v + ((g == 2'h0) ? 0 : (g == 2'h1) ? 1 : 2);
    return (s > 32) ? CREDIT_MAX : CREDIT_W'(s);
  endfunction

  // Source beats wait for acceptance with a bounded loop
  task automatic send(input int n, input logic np, input logic [IDX_W-1:0] ld);
    int t;
    for (int b = 0; b < n; b++) begin
      @(negedge sys_clk);
      src_valid = 1'b1;
      src_data = {16{$random(seed)}};
      src_sideband = src_data[SIDE_W-1:0];
      src_packet_end = (b == n - 1);
      src_last_dword = ld;
      src_nonposted = np;
      for (t = 0; t < 300; t++) begin
        #1;
        if (src_ready === 1'b1) break;
        @(negedge sys_clk);
      end
      if (t == 300) begin
        errors++;
        print_verdict();
      end
      @(posedge sys_clk);
      q_data.push_back(src_data);
      q_end.push_back(src_packet_end);
      q_ld.push_back(ld);
    end
    @(negedge sys_clk);
    src_valid = 1'b0;
  endtask

  task automatic credit(input logic [1:0] g, input logic [CREDIT_W-1:0] exp);
    @(negedge sys_clk);
    nonposted_credit_grant = g;
    @(negedge sys_clk);
    nonposted_credit_grant = 2'h0;
    repeat (2) @(negedge sys_clk);
    check(nonposted_credit_level, exp);
  endtask

  // ****************************************************************
  // Output monitor
  // ****************************************************************
  always @(posedge sys_clk) begin
    if (in_pkt || stalled) check(req_stream_valid, 1'b1);
    if (stalled) check(req_stream_data, held);
    stalled = !rst && req_stream_valid && !req_stream_ready;
    held = req_stream_data;
    if (!rst && req_stream_valid && req_stream_ready && q_data.size() > 0) begin
      d = q_data.pop_front();
      e = q_end.pop_front();
      l = q_ld.pop_front();
      // Framing comes from the bench's own record, since straddle holds packet end at zero
      in_pkt = !e;
      check(req_stream_data, d);
      check(req_stream_sideband, d[SIDE_W-1:0]);
      check(req_stream_packet_end, e && !straddle_enable);
      check(req_stream_dword_mask, exp_mask(e, l));
    end
  end

  initial begin
    {rst, link_up, straddle_enable, src_valid, src_packet_end, src_nonposted} = 6'b110000;
    {src_data, src_sideband, src_last_dword, nonposted_credit_grant, pace} = '0;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    check(nonposted_credit_level, 6'h00);
    // A non-posted head without credit is held; once it is withdrawn, posted traffic flows
    {src_valid, src_nonposted, src_packet_end} = 3'b111;
    repeat (4) @(negedge sys_clk);
    #1 check(src_ready, 1'b0);
    src_valid = 1'b0;
    send(2, 1'b0, 4'h3);
    c = '0;
    for (i = 0; i < 4; i++) begin
      c = add(c, i[1:0]);
      credit(i[1:0], c);
    end
    send(1, 1'b1, 4'h0);
    repeat (3) @(negedge sys_clk);
    c = c - 6'h01;
    check(nonposted_credit_level, c);
    for (i = 0; i < 16; i++) begin
      c = add(c, 2'h3);
      credit(2'h3, c);
    end
    // Mid-run reset while the credit count sits at saturation
    rst = 1'b1;
    @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    check(nonposted_credit_level, 6'h00);
    credit(2'h3, 6'h02);
    link_up = 1'b0;
    @(negedge sys_clk);
    link_up = 1'b1;
    repeat (2) @(negedge sys_clk);
    check(nonposted_credit_level, 6'h00);
    pace = 2'h2;
    send(1, 1'b0, 4'h7);
    repeat (5) @(negedge sys_clk);
    nonposted_credit_grant = 2'h3;
    for (i = 0; i < 40; i++) begin
      pace = (i % 3 == 0) ? 2'h0 : 2'h1;
      // Straddle is a static option: switch it only once the stream has drained
      for (int w = 0; i == 28 && w < 300 && q_data.size() > 0; w++) @(negedge sys_clk);
      if (i == 28) check(q_data.size(), 0);
      straddle_enable = (i >= 28);
      send(($random(seed) & 3) + 1, 1'($random(seed)), 4'($random(seed)));
    end
    repeat (20) @(negedge sys_clk);
    check(q_data.size(), 0);
    print_verdict();
  end
endmodule // testbench
